/* File: rtl/dccr_defines.svh */
// Purpose: Addresses, field positions, reset values and codes of the
//          converter channel configuration registers.
// Assumes: Eight channels, two mode bits each, byte-wide registers.
// Notes:   Definitions only; included by its bare name.
`ifndef DCCR_DEFINES_SVH
`define DCCR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DCCR_ADDR_MODE_LOW 8'h20
`define DCCR_ADDR_MODE_HIGH 8'h21
`define DCCR_ADDR_SPAN 8'h2A
`define DCCR_ADDR_REF 8'h3C
`define DCCR_ADDR_MON 8'h93

// ----------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------
`define DCCR_ADDR_W 8
`define DCCR_DATA_W 8
`define DCCR_MODE_W 2
`define DCCR_CHAN_PER_REG 4
`define DCCR_SPAN_BIT 2
`define DCCR_REF_BIT 0
`define DCCR_MON_W 5
`define DCCR_CHAN_IDX_W 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DCCR_RST_MODE_REG 8'hFF
`define DCCR_RST_SPAN 1'h0
`define DCCR_RST_REF 1'h0
`define DCCR_RST_MON 5'h00
`define DCCR_RST_ALL_ON 8'hFF
`define DCCR_RST_ALL_OFF 8'h00
`define DCCR_RD_ZERO 8'h00

// ----------------------------------------------------------------------
// Channel mode and monitor codes
// ----------------------------------------------------------------------
`define DCCR_MODE_NORMAL 2'h0
`define DCCR_MODE_PD_1K 2'h1
`define DCCR_MODE_PD_7K7 2'h2
`define DCCR_MODE_PD_32K 2'h3
`define DCCR_MON_OFF 5'h00
`define DCCR_MON_FIRST 5'h01
`define DCCR_MON_LAST 5'h18
`define DCCR_MON_TEMP 5'h19
`define DCCR_MON_GND 5'h1A
`define DCCR_MON_STEP 5'h03
`define DCCR_MON_SLOT_VOLT 5'h00
`define DCCR_MON_SLOT_SOURCE 5'h01

`endif

/* File: rtl/dccr_pkg.sv */
// Purpose: Types shared by the channel configuration modules.
// Assumes: dccr_defines.svh gives the codes.
// Notes:   Nothing here is imported; users write dccr_pkg::name.
`include "dccr_defines.svh"

package dccr_pkg;

  typedef enum logic [1:0] {
    DCCR_NORMAL = `DCCR_MODE_NORMAL,
    DCCR_PD_1K = `DCCR_MODE_PD_1K,
    DCCR_PD_7K7 = `DCCR_MODE_PD_7K7,
    DCCR_PD_32K = `DCCR_MODE_PD_32K
  } dccr_mode_type;

  typedef enum logic [2:0] {
    DCCR_SRC_NONE = 3'h0,
    DCCR_SRC_VOLT = 3'h1,
    DCCR_SRC_SOURCE = 3'h2,
    DCCR_SRC_SINK = 3'h3,
    DCCR_SRC_TEMP = 3'h4,
    DCCR_SRC_GROUND = 3'h5
  } dccr_mon_kind_type;

endpackage : dccr_pkg

/* File: rtl/dccr_mon_if.sv */
// Purpose: Carries the monitor select code and its decoded meaning.
// Assumes: One decoder and one user.
// Notes:   Internal to the configuration block.
`timescale 1ns/1ps
`include "dccr_defines.svh"

interface dccr_mon_if;
  logic [`DCCR_MON_W-1:0] selCode;
  logic powerDown;
  logic [`DCCR_CHAN_IDX_W-1:0] channel;
  dccr_pkg::dccr_mon_kind_type kind;

  modport decoder (input selCode, output powerDown, output channel,
                   output kind);
  modport user (output selCode, input powerDown, input channel,
                input kind);
endinterface : dccr_mon_if

/* File: rtl/dccr_monitor_decode.sv */
// Purpose: Turns the monitor select code into a source kind and channel.
// Assumes: Code is stable from a register on the same clock.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "dccr_defines.svh"

module dccr_monitor_decode (
  dccr_mon_if.decoder mon
);

  // Offset of a channel code from the first channel code.
  function automatic logic [`DCCR_MON_W-1:0] chanOffset(
    input logic [`DCCR_MON_W-1:0] code
  );
    chanOffset = code - `DCCR_MON_FIRST;
  endfunction : chanOffset

  wire [`DCCR_MON_W-1:0] offset = chanOffset(mon.selCode);
  wire [`DCCR_MON_W-1:0] group = offset / `DCCR_MON_STEP;
  wire [`DCCR_MON_W-1:0] slot = offset % `DCCR_MON_STEP;
  wire isChan = (mon.selCode >= `DCCR_MON_FIRST) &&
                (mon.selCode <= `DCCR_MON_LAST);
  wire isTemp = (mon.selCode == `DCCR_MON_TEMP);
  wire isGnd = (mon.selCode == `DCCR_MON_GND);

  // Three codes per channel: voltage, sourcing current, sinking current.
  wire dccr_pkg::dccr_mon_kind_type chanKind =
    (slot == `DCCR_MON_SLOT_VOLT) ? dccr_pkg::DCCR_SRC_VOLT :
    (slot == `DCCR_MON_SLOT_SOURCE) ? dccr_pkg::DCCR_SRC_SOURCE :
    dccr_pkg::DCCR_SRC_SINK;

  assign mon.channel = isChan ? group[`DCCR_CHAN_IDX_W-1:0] :
                       {`DCCR_CHAN_IDX_W{1'b0}};
  assign mon.kind = isChan ? chanKind :
                    isTemp ? dccr_pkg::DCCR_SRC_TEMP :
                    isGnd ? dccr_pkg::DCCR_SRC_GROUND :
                    dccr_pkg::DCCR_SRC_NONE;
  // Code zero and the undefined top codes both leave the pin powered down.
  assign mon.powerDown = !(isChan || isTemp || isGnd);

endmodule : dccr_monitor_decode

/* File: rtl/dccr_config_regs.sv */
// Purpose: Configuration registers of an eight-channel voltage-output
//          converter: channel modes, output span, reference source and
//          analog monitor selection, with decoded analog controls.
// Assumes: The serial interface engine on mclk presents byte writes and
//          reads by address; its inputs need no synchroniser.
// Notes:   Decoded controls follow the registers one enabled mclk edge later.
//          Undefined monitor codes are stored and read as written.
//
// How it works
// - Mode codes: normal, or three power-down impedances.
// - Every channel mode resets to 32 kilohm.
// - Four mode fields per byte, low channel lowest.
// - Bit two selects one or two reference spans.
// - Bit zero selects internal reference driven out.
// - Monitor select resets zero, zero powers down.
// - Codes 1 to 24 step channels by three.
// - Code 25 temperature, code 26 analog ground.
// - Reserved bits read zero, ignore writes.
// - Low channel modes at 0x20, reset 0xFF.
`timescale 1ns/1ps
`include "dccr_defines.svh"

module dccr_config_regs #(
  parameter int NUM_CHAN = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [`DCCR_ADDR_W-1:0] regAddr,
  input wire logic [`DCCR_DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [`DCCR_DATA_W-1:0] regRdData,
  output logic regRdValid,
  output logic [NUM_CHAN-1:0] chanNormal,
  output logic [NUM_CHAN-1:0] chanPd1k,
  output logic [NUM_CHAN-1:0] chanPd7k7,
  output logic [NUM_CHAN-1:0] chanPd32k,
  output logic spanDouble,
  output logic refInternal,
  output logic refPinDrive,
  output logic monPowerDown,
  output logic [`DCCR_CHAN_IDX_W-1:0] monChannel,
  output logic monVoltSel,
  output logic monSourceSel,
  output logic monSinkSel,
  output logic monTempSel,
  output logic monGroundSel
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Compares a two-bit mode field with one mode.
  function automatic logic modeIs(
    input logic [`DCCR_MODE_W-1:0] field,
    input dccr_pkg::dccr_mode_type mode
  );
    modeIs = (dccr_pkg::dccr_mode_type'(field) == mode);
  endfunction : modeIs

  // Address decode used by both the write and the read paths.
  function automatic logic addrIs(
    input logic [`DCCR_ADDR_W-1:0] addr,
    input logic [`DCCR_ADDR_W-1:0] target
  );
    addrIs = (addr == target);
  endfunction : addrIs

  // Places a one-bit field at its position in an otherwise zero byte.
  function automatic logic [`DCCR_DATA_W-1:0] placeBit(
    input logic value,
    input int pos
  );
    placeBit = `DCCR_RD_ZERO;
    placeBit[pos] = value;
  endfunction : placeBit

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------

  logic [`DCCR_DATA_W-1:0] modeLow_q;
  logic [`DCCR_DATA_W-1:0] modeHigh_q;
  logic span_q;
  logic refSel_q;
  logic [`DCCR_MON_W-1:0] monSel_q;
  logic [`DCCR_DATA_W-1:0] rdData_q;
  logic [`DCCR_DATA_W-1:0] rdData_d;
  logic rdValid_q;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------

  wire hitModeLow = addrIs(regAddr, `DCCR_ADDR_MODE_LOW);
  wire hitModeHigh = addrIs(regAddr, `DCCR_ADDR_MODE_HIGH);
  wire hitSpan = addrIs(regAddr, `DCCR_ADDR_SPAN);
  wire hitRef = addrIs(regAddr, `DCCR_ADDR_REF);
  wire hitMon = addrIs(regAddr, `DCCR_ADDR_MON);

  // A write strobe is taken only on an enabled edge.
  wire wrTaken = clkEn && regWrEn;
  wire wrModeLow = wrTaken && hitModeLow;
  wire wrModeHigh = wrTaken && hitModeHigh;
  wire wrSpan = wrTaken && hitSpan;
  wire wrRef = wrTaken && hitRef;
  wire wrMon = wrTaken && hitMon;

  // Only the defined field of each mixed register is kept.
  wire spanBitIn = regWrData[`DCCR_SPAN_BIT];
  wire refBitIn = regWrData[`DCCR_REF_BIT];
  wire [`DCCR_MON_W-1:0] monIn = regWrData[`DCCR_MON_W-1:0];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      modeLow_q <= `DCCR_RST_MODE_REG;
      modeHigh_q <= `DCCR_RST_MODE_REG;
    end
    else
    begin
      if (wrModeLow)
        modeLow_q <= regWrData;
      if (wrModeHigh)
        modeHigh_q <= regWrData;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      span_q <= `DCCR_RST_SPAN;
      refSel_q <= `DCCR_RST_REF;
      monSel_q <= `DCCR_RST_MON;
    end
    else
    begin
      if (wrSpan)
        span_q <= spanBitIn;
      if (wrRef)
        refSel_q <= refBitIn;
      if (wrMon)
        monSel_q <= monIn;
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  // Reserved positions are filled with zero before the field is placed.
  wire [`DCCR_DATA_W-1:0] spanRead =
    placeBit(span_q, `DCCR_SPAN_BIT);
  wire [`DCCR_DATA_W-1:0] refRead =
    placeBit(refSel_q, `DCCR_REF_BIT);
  wire [`DCCR_DATA_W-1:0] monRead =
    {{(`DCCR_DATA_W-`DCCR_MON_W){1'b0}}, monSel_q};

  // An unmapped address reads as zero.
  always_comb
  begin
    rdData_d = `DCCR_RD_ZERO;
    if (hitModeLow)
      rdData_d = modeLow_q;
    else if (hitModeHigh)
      rdData_d = modeHigh_q;
    else if (hitSpan)
      rdData_d = spanRead;
    else if (hitRef)
      rdData_d = refRead;
    else if (hitMon)
      rdData_d = monRead;
  end

  // A read in the same cycle as a write to that address sees the old value.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdData_q <= `DCCR_RD_ZERO;
      rdValid_q <= 1'b0;
    end
    else if (clkEn)
    begin
      rdValid_q <= regRdEn;
      if (regRdEn)
        rdData_q <= rdData_d;
    end
  end

  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;

  // ----------------------------------------------------------------------
  // Channel mode decode
  // ----------------------------------------------------------------------

  wire [2*`DCCR_DATA_W-1:0] modeAll = {modeHigh_q, modeLow_q};
  logic [NUM_CHAN-1:0] normal_d;
  logic [NUM_CHAN-1:0] pd1k_d;
  logic [NUM_CHAN-1:0] pd7k7_d;
  logic [NUM_CHAN-1:0] pd32k_d;

  for (genvar ch = 0; ch < NUM_CHAN; ch++)
  begin : g_chan
    // Channel ch sits at bits [2ch+1:2ch] of the joined mode bytes.
    wire [`DCCR_MODE_W-1:0] field =
      modeAll[`DCCR_MODE_W*ch +: `DCCR_MODE_W];
    assign normal_d[ch] = modeIs(field, dccr_pkg::DCCR_NORMAL);
    assign pd1k_d[ch] = modeIs(field, dccr_pkg::DCCR_PD_1K);
    assign pd7k7_d[ch] = modeIs(field, dccr_pkg::DCCR_PD_7K7);
    assign pd32k_d[ch] = modeIs(field, dccr_pkg::DCCR_PD_32K);
  end

  // ----------------------------------------------------------------------
  // Monitor decode
  // ----------------------------------------------------------------------

  dccr_mon_if monBus ();

  assign monBus.selCode = monSel_q;

  dccr_monitor_decode u_mon_decode (
    .mon(monBus.decoder)
  );

  wire monVolt_d = (monBus.kind == dccr_pkg::DCCR_SRC_VOLT);
  wire monSource_d = (monBus.kind == dccr_pkg::DCCR_SRC_SOURCE);
  wire monSink_d = (monBus.kind == dccr_pkg::DCCR_SRC_SINK);
  wire monTemp_d = (monBus.kind == dccr_pkg::DCCR_SRC_TEMP);
  wire monGnd_d = (monBus.kind == dccr_pkg::DCCR_SRC_GROUND);

  // ----------------------------------------------------------------------
  // Registered analog controls
  // ----------------------------------------------------------------------

  // Outputs leave reset in the state the reset register values imply, so
  // the analog side never sees a glitch toward normal operation.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chanNormal <= NUM_CHAN'(`DCCR_RST_ALL_OFF);
      chanPd1k <= NUM_CHAN'(`DCCR_RST_ALL_OFF);
      chanPd7k7 <= NUM_CHAN'(`DCCR_RST_ALL_OFF);
      chanPd32k <= NUM_CHAN'(`DCCR_RST_ALL_ON);
    end
    else if (clkEn)
    begin
      chanNormal <= normal_d;
      chanPd1k <= pd1k_d;
      chanPd7k7 <= pd7k7_d;
      chanPd32k <= pd32k_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      spanDouble <= `DCCR_RST_SPAN;
      refInternal <= `DCCR_RST_REF;
      refPinDrive <= `DCCR_RST_REF;
    end
    else if (clkEn)
    begin
      spanDouble <= span_q;
      refInternal <= refSel_q;
      // The pin is an output exactly while the internal source is used.
      refPinDrive <= refSel_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      monPowerDown <= 1'b1;
      monChannel <= {`DCCR_CHAN_IDX_W{1'b0}};
      monVoltSel <= 1'b0;
      monSourceSel <= 1'b0;
      monSinkSel <= 1'b0;
      monTempSel <= 1'b0;
      monGroundSel <= 1'b0;
    end
    else if (clkEn)
    begin
      monPowerDown <= monBus.powerDown;
      monChannel <= monBus.channel;
      monVoltSel <= monVolt_d;
      monSourceSel <= monSource_d;
      monSinkSel <= monSink_d;
      monTempSel <= monTemp_d;
      monGroundSel <= monGnd_d;
    end
  end

endmodule : dccr_config_regs

/* File: verification/dccr_host.sv */
// Purpose: Serial-engine side that issues byte writes and reads.
// Assumes: Requests change just after a rising mclk edge.
// Notes:   Released address and data lines show the inverse value.
`timescale 1ns/1ps

module dccr_host (
  input wire logic mclk,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic regWrEn,
  output logic regRdEn
);
  // ----------
  // Byte access
  // ----------
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'h0;
    regRdEn = 1'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'h1;
    @(posedge mclk);
    regWrEn <= 1'h0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'h1;
    @(posedge mclk);
    regRdEn <= 1'h0;
    regAddr <= ~a;
  endtask : rd
endmodule : dccr_host

/* File: verification/dccr_config_regs_chk.sv */
// Purpose: Port assertions for the channel configuration registers.
// Assumes: One clock domain, reset_n low resets.
// Notes:   Bound into every dccr_config_regs instance.
`timescale 1ns/1ps

module dccr_config_regs_chk #(
  parameter int NUM_CHAN = 8
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic [NUM_CHAN-1:0] chanNormal,
  input wire logic [NUM_CHAN-1:0] chanPd1k,
  input wire logic [NUM_CHAN-1:0] chanPd7k7,
  input wire logic [NUM_CHAN-1:0] chanPd32k,
  input wire logic spanDouble,
  input wire logic refInternal,
  input wire logic refPinDrive,
  input wire logic monPowerDown,
  input wire logic [2:0] monChannel,
  input wire logic monVoltSel,
  input wire logic monSourceSel,
  input wire logic monSinkSel,
  input wire logic monTempSel,
  input wire logic monGroundSel
);
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // A taken write followed by the enabled edge that updates outputs.
  sequence s_wr(logic [7:0] ad);
    clkEn && regWrEn && regAddr == ad ##1 clkEn;
  endsequence

  a_mode_one: assert property (
    (chanNormal | chanPd1k | chanPd7k7 | chanPd32k) == {NUM_CHAN{1'h1}}
    && $countones({chanNormal, chanPd1k, chanPd7k7, chanPd32k}) == NUM_CHAN)
    else $error("channel mode lines not one per channel");
  a_mon_one: assert property ($onehot({monPowerDown, monVoltSel,
    monSourceSel, monSinkSel, monTempSel, monGroundSel}))
    else $error("monitor selects not one-hot");
  a_reset_state: assert property ($rose(reset_n) |->
    chanPd32k == {NUM_CHAN{1'h1}} && monPowerDown && !spanDouble)
    else $error("outputs wrong after reset");
  a_ch0_mode: assert property (s_wr(8'h20) |=>
    chanNormal[0] == ($past(regWrData[1:0], 2) == 2'h0))
    else $error("channel 0 mode not from low byte bits 1:0");
  a_ch7_mode: assert property (s_wr(8'h21) |=>
    chanPd7k7[7] == ($past(regWrData[7:6], 2) == 2'h2))
    else $error("channel 7 mode not from high byte bits 7:6");
  a_span_bit: assert property (s_wr(8'h2A) |=>
    spanDouble == $past(regWrData[2], 2))
    else $error("span output does not follow bit 2");
  a_ref_bit: assert property (s_wr(8'h3C) |=>
    refInternal == $past(regWrData[0], 2) && refPinDrive == refInternal)
    else $error("reference select does not follow bit 0");
  a_mon_volt: assert property (s_wr(8'h93) |=>
    (monVoltSel || monSourceSel || monSinkSel)
    == ($past(regWrData[4:0], 2) inside {[5'h01:5'h18]}))
    else $error("channel monitor codes misdecoded");
  a_mon_off: assert property (s_wr(8'h93) |=>
    monPowerDown == ($past(regWrData[4:0], 2) == 5'h00
    || $past(regWrData[4:0], 2) > 5'h1A))
    else $error("monitor power down misdecoded");
  a_mon_temp: assert property (s_wr(8'h93) |=>
    monTempSel == ($past(regWrData[4:0], 2) == 5'h19))
    else $error("temperature monitor misdecoded");
  a_rsvd_read: assert property (
    clkEn && regRdEn && regAddr == 8'h2A |=> regRdData[7:3] == 5'h00
    && regRdData[1:0] == 2'h0)
    else $error("reserved span bits read nonzero");
  a_rd_valid: assert property (clkEn |=> regRdValid == $past(regRdEn))
    else $error("read valid not one cycle after read");
  a_enable_freeze: assert property (!clkEn |=> $stable(regRdData)
    && $stable(spanDouble) && $stable(chanPd32k))
    else $error("state changed with clock enable low");
endmodule : dccr_config_regs_chk

bind dccr_config_regs dccr_config_regs_chk #(.NUM_CHAN(NUM_CHAN)) uChk (.*);

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the channel configuration registers.
// Assumes: dccr_host issues the byte accesses.
// Notes:   Outputs are checked one enabled edge after each write.
`timescale 1ns/1ps

module tb;
  logic mclk = 1'h0;
  logic reset_n = 1'h0;
  logic clkEn = 1'h1;
  logic [7:0] regAddr, regWrData, regRdData;
  logic regWrEn, regRdEn, regRdValid, spanDouble, refInternal, refPinDrive;
  logic [7:0] chanNormal, chanPd1k, chanPd7k7, chanPd32k;
  logic monPowerDown, monVoltSel, monSourceSel, monSinkSel;
  logic monTempSel, monGroundSel;
  logic [2:0] monChannel;
  int mismatches = 0;
  int checkCount = 0;
  int cyc = 0;
  wire [31:0] chanVec = {chanNormal, chanPd1k, chanPd7k7, chanPd32k};
  wire [8:0] monVec = {monPowerDown, monVoltSel, monSourceSel, monSinkSel,
    monTempSel, monGroundSel, monChannel};

  always #20 mclk = ~mclk;

  dccr_host host (.*);
  dccr_config_regs #(.NUM_CHAN(8)) DUT (.*);

  // ----------
  // Tasks
  // ----------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_out

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a);
    #1;
    chk_out({31'h0, regRdValid}, 32'h1);
    chk_rd(regRdData, exp);
  endtask : rdc

  task automatic wrs(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    @(posedge mclk);
    #1;
  endtask : wrs

  // Bits: power down, volt, source, sink, temperature, ground, channel.
  function automatic logic [8:0] mon_exp(input logic [4:0] k);
    logic [4:0] j;
    j = k - 5'h01;
    if (k == 5'h00 || k > 5'h1A)
      return 9'h100;
    if (k == 5'h19)
      return 9'h010;
    if (k == 5'h1A)
      return 9'h008;
    return {1'h0, 3'h4 >> (j % 3), 2'h0, 3'(j / 3)};
  endfunction : mon_exp

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      close_out;
    end
  end

  // ----------
  // Tests
  // ----------
  initial
  begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'h1;
    #1;
    chk_out(chanVec, 32'h000000FF);
    chk_out({23'h0, monVec}, 32'h100);
    rdc(8'h20, 8'hFF);
    rdc(8'h21, 8'hFF);
    rdc(8'h2A, 8'h00);
    rdc(8'h3C, 8'h00);
    rdc(8'h93, 8'h00);
    $display("reset values test done");
    for (int m = 0; m < 4; m++)
    begin
      wrs(8'h20, {4{2'(m)}});
      wrs(8'h21, {4{2'(m)}});
      chk_out(chanVec, 32'hFF << (8 * (3 - m)));
    end
    wrs(8'h20, 8'h1B);
    wrs(8'h21, 8'h1B);
    chk_out(chanVec, 32'h88442211);
    rdc(8'h21, 8'h1B);
    $display("channel mode test done");
    wrs(8'h2A, 8'hFF);
    wrs(8'h3C, 8'hFF);
    rdc(8'h2A, 8'h04);
    rdc(8'h3C, 8'h01);
    chk_out({29'h0, spanDouble, refInternal, refPinDrive}, 32'h7);
    wrs(8'h2A, 8'hFB);
    wrs(8'h3C, 8'hFE);
    chk_out({29'h0, spanDouble, refInternal, refPinDrive}, 32'h0);
    wrs(8'h93, 8'hE5);
    rdc(8'h93, 8'h05);
    $display("reserved bits test done");
    for (int k = 0; k < 32; k++)
    begin
      wrs(8'h93, 8'(k));
      chk_out({23'h0, monVec}, {23'h0, mon_exp(5'(k))});
    end
    rdc(8'h93, 8'h1F);
    $display("monitor select test done");
    wrs(8'h22, 8'h00);
    rdc(8'h22, 8'h00);
    chk_out(chanVec, 32'h88442211);
    @(posedge mclk);
    clkEn <= 1'h0;
    host.wr(8'h2A, 8'h04);
    @(posedge mclk);
    #1;
    chk_out({31'h0, spanDouble}, 32'h0);
    @(posedge mclk);
    clkEn <= 1'h1;
    rdc(8'h2A, 8'h00);
    $display("unmapped and freeze test done");
    @(posedge mclk);
    reset_n <= 1'h0;
    @(posedge mclk);
    #1;
    chk_out(chanVec, 32'h000000FF);
    @(posedge mclk);
    reset_n <= 1'h1;
    rdc(8'h20, 8'hFF);
    $display("second reset test done");
    close_out;
  end
endmodule : tb
